/* File: hpc_pkg.sv */
// constants for the haptic playback configuration register bank
package hpc_pkg;
    // ----------------------------------------
    // register offsets
    // ----------------------------------------
    localparam logic [7:0] OFS_GO = 8'h0C;
    localparam logic [7:0] OFS_LIB_CFG = 8'h0D;
    localparam logic [7:0] OFS_RT_DRIVE = 8'h0E;
    localparam logic [7:0] OFS_SLOT_ONE = 8'h0F;
    // ----------------------------------------
    // field positions
    // ----------------------------------------
    localparam int BIT_LIB_ACTIVE = 7;
    localparam int BIT_LIB_SEL = 6;
    localparam int BIT_INTERVAL = 5;
    localparam int BIT_SLOT_DELAY = 7;
    // ----------------------------------------
    // reset values
    // ----------------------------------------
    localparam logic [7:0] RST_LIB_CFG = 8'h00;
    localparam logic [7:0] RST_RT_DRIVE = 8'h7F;
    localparam logic [7:0] RST_SLOT_ONE = 8'h01;
    // ----------------------------------------
    // timing
    // ----------------------------------------
    localparam int CLK_HZ = 10_000_000;
    localparam int STEP_SLOW_MS = 5;
    localparam int STEP_FAST_MS = 1;
    localparam int DELAY_UNIT_MS = 10;
    localparam int STEP_SLOW_CYC = STEP_SLOW_MS * (CLK_HZ / 1000);
    localparam int STEP_FAST_CYC = STEP_FAST_MS * (CLK_HZ / 1000);
    localparam int DELAY_UNIT_CYC = DELAY_UNIT_MS * (CLK_HZ / 1000);
    // ----------------------------------------
    // playback modes
    // ----------------------------------------
    typedef enum logic [1:0] {
        HPC_MODE_LIBRARY = 2'b00,
        HPC_MODE_REALTIME = 2'b01
    } hpc_mode_e;
endpackage

/* File: hpc_regs.sv */
// haptic playback configuration registers with drive level and step timing
`timescale 1ns/1ps
`default_nettype none
// Summary of operation
// - a read-only library-active flag resets to 0 and becomes 1 once a library is selected.
// - library select 0 picks the closed-loop resonant library, 1 the open-loop eccentric one.
// - the playback step comes every 5 ms with interval bit 0 and every 1 ms with it 1.
// - library amplitude scales to 100, 75, 50 or 25 percent for attenuation 0 to 3.
// - attenuation is not applied while in real-time playback mode.
// - in real-time mode once started, the load is driven with the real-time drive value.
// - the real-time drive value is a signed byte that resets to 127.
// - a new real-time value reaches the drive without a re-trigger.
// - the start bit launches the process, stays 1 until done, and clearing it cancels.
// - a slot with its delay flag set idles 10 ms times its seven-bit value.
// - the sequencer starts at slot one and stops on a zero identifier or after the last slot.
module hpc_regs #(
    parameter int STEP_SLOW = hpc_pkg::STEP_SLOW_CYC,
    parameter int STEP_FAST = hpc_pkg::STEP_FAST_CYC
) (
    // clock and reset
    input wire logic clk_sys,
    input wire logic sys_rst,
    // register port
    input wire logic reg_wr,
    input wire logic [7:0] reg_addr,
    input wire logic [7:0] reg_wdata,
    output logic [7:0] reg_rdata,
    // engine side
    input wire logic mode_realtime,
    input wire logic go_active,
    input wire logic signed [7:0] library_sample,
    output logic library_select,
    output logic playback_step,
    output logic signed [7:0] drive_level,
    output logic [6:0] slot1_waveform_id,
    output logic slot1_delay_flag
);
    // ----------------------------------------
    // registers
    // ----------------------------------------
    logic [7:0] lib_cfg;
    logic [7:0] realtime_drive_value;
    logic [7:0] slot_one;
    logic lib_active;
    logic [22:0] step_cnt;
    wire wr_lib = reg_wr && reg_addr == hpc_pkg::OFS_LIB_CFG;
    wire wr_rt = reg_wr && reg_addr == hpc_pkg::OFS_RT_DRIVE;
    wire wr_slot = reg_wr && reg_addr == hpc_pkg::OFS_SLOT_ONE;
    wire [1:0] library_attenuation = lib_cfg[1:0];
    always_ff @(posedge clk_sys or posedge sys_rst) begin
        if (sys_rst) begin
            lib_cfg <= hpc_pkg::RST_LIB_CFG;
            realtime_drive_value <= hpc_pkg::RST_RT_DRIVE;
            slot_one <= hpc_pkg::RST_SLOT_ONE;
            lib_active <= 1'b0;
        end else begin
            if (wr_lib) begin
                lib_cfg <= reg_wdata;
                lib_active <= 1'b1;
            end
            if (wr_rt) begin
                realtime_drive_value <= reg_wdata;
            end
            if (wr_slot) begin
                slot_one <= reg_wdata;
            end
        end
    end
    // ----------------------------------------
    // read path, reserved bits read as written
    // ----------------------------------------
    wire [7:0] lib_rd = {lib_active, lib_cfg[6:0]};
    wire [7:0] next_rdata = (reg_addr == hpc_pkg::OFS_LIB_CFG) ? lib_rd :
                            (reg_addr == hpc_pkg::OFS_RT_DRIVE) ? realtime_drive_value :
                            (reg_addr == hpc_pkg::OFS_SLOT_ONE) ? slot_one : 8'h00;
    // ----------------------------------------
    // step divider
    // ----------------------------------------
    wire [22:0] step_last = lib_cfg[hpc_pkg::BIT_INTERVAL] ? 23'(STEP_FAST - 1) :
                                                            23'(STEP_SLOW - 1);
    wire step_hit = step_cnt >= step_last;
    // ----------------------------------------
    // attenuation: shifts keep it multiplier free
    // ----------------------------------------
    wire signed [9:0] s10 = 10'(library_sample);
    wire signed [9:0] att_q3 = (s10 >>> 1) + (s10 >>> 2);
    wire signed [9:0] att_sel = (library_attenuation == 2'h0) ? s10 :
                                (library_attenuation == 2'h1) ? att_q3 :
                                (library_attenuation == 2'h2) ? (s10 >>> 1) :
                                (s10 >>> 2);
    wire signed [7:0] next_drive = !go_active ? 8'sh00 :
                                   mode_realtime ? realtime_drive_value :
                                   att_sel[7:0];
    always_ff @(posedge clk_sys or posedge sys_rst) begin
        if (sys_rst) begin
            step_cnt <= 23'h00_0000;
            playback_step <= 1'b0;
            drive_level <= 8'sh00;
            reg_rdata <= 8'h00;
            library_select <= 1'b0;
            slot1_waveform_id <= hpc_pkg::RST_SLOT_ONE[6:0];
            slot1_delay_flag <= hpc_pkg::RST_SLOT_ONE[hpc_pkg::BIT_SLOT_DELAY];
        end else begin
            // counter restarts with each playback so the first step is a full interval
            step_cnt <= (!go_active || step_hit) ? 23'h00_0000 : step_cnt + 23'h00_0001;
            playback_step <= go_active && step_hit;
            drive_level <= next_drive;
            reg_rdata <= next_rdata;
            library_select <= lib_cfg[hpc_pkg::BIT_LIB_SEL];
            slot1_waveform_id <= slot_one[6:0];
            slot1_delay_flag <= slot_one[hpc_pkg::BIT_SLOT_DELAY];
        end
    end

    // ----------------------------------------
    // check helpers
    // ----------------------------------------
    // cycles since the last step; only an upper bound, since an
    // interval change in mid-count shortens one gap on purpose
    logic [22:0] chk_gap;
    always_ff @(posedge clk_sys or posedge sys_rst) begin
        if (sys_rst) begin
            chk_gap <= 23'h00_0001;
        end else begin
            chk_gap <= (playback_step || !go_active) ? 23'h00_0001 : chk_gap + 23'h00_0001;
        end
    end

    // ----------------------------------------
    // check sequences: steps of a register write and playback running states
    // ----------------------------------------
    // write cycle on the library word
    sequence lib_write_s;
        wr_lib;
    endsequence
    // no further write on the library word
    sequence lib_quiet_s;
        !wr_lib;
    endsequence
    // write cycle on the real-time word
    sequence rt_write_s;
        wr_rt;
    endsequence
    // real-time playback running
    sequence rt_running_s;
        go_active && mode_realtime;
    endsequence
    // library playback running
    sequence lib_running_s;
        go_active && !mode_realtime;
    endsequence
    // write cycle on the first slot word
    sequence slot_write_s;
        wr_slot;
    endsequence

    // ----------------------------------------
    // checks: library word
    // ----------------------------------------
    lib_flag_a: assert property (@(posedge clk_sys) disable iff (sys_rst)
        lib_write_s |=> lib_active)
        else $error("library flag not set");
    lib_keep_a: assert property (@(posedge clk_sys) disable iff (sys_rst)
        lib_active |=> lib_active)
        else $error("library flag dropped");
    lib_read_a: assert property (@(posedge clk_sys) disable iff (sys_rst)
        reg_addr == hpc_pkg::OFS_LIB_CFG
        |=> reg_rdata[hpc_pkg::BIT_LIB_ACTIVE] == $past(lib_active))
        else $error("library flag read wrong");
    lib_sel_a: assert property (@(posedge clk_sys) disable iff (sys_rst)
        lib_write_s ##1 lib_quiet_s
        |=> library_select == $past(reg_wdata[hpc_pkg::BIT_LIB_SEL], 2))
        else $error("library select wrong");

    // ----------------------------------------
    // checks: step pulse
    // ----------------------------------------
    step_gap_a: assert property (@(posedge clk_sys) disable iff (sys_rst)
        playback_step |=> !playback_step)
        else $error("step too close");
    step_live_a: assert property (@(posedge clk_sys) disable iff (sys_rst)
        playback_step |-> $past(go_active))
        else $error("step without playback");
    step_span_a: assert property (@(posedge clk_sys) disable iff (sys_rst)
        go_active |-> chk_gap <= 23'(STEP_SLOW + 1))
        else $error("step interval too long");

    // ----------------------------------------
    // checks: drive level
    // ----------------------------------------
    att_full_a: assert property (@(posedge clk_sys) disable iff (sys_rst)
        lib_running_s ##0 (library_attenuation == 2'h0)
        |=> drive_level == $past(library_sample))
        else $error("full strength wrong");
    att_three_a: assert property (@(posedge clk_sys) disable iff (sys_rst)
        lib_running_s ##0 (library_attenuation == 2'h1)
        |=> drive_level == ($past(library_sample) >>> 1) + ($past(library_sample) >>> 2))
        else $error("three quarter strength wrong");
    att_half_a: assert property (@(posedge clk_sys) disable iff (sys_rst)
        lib_running_s ##0 (library_attenuation == 2'h2)
        |=> drive_level == ($past(library_sample) >>> 1))
        else $error("half strength wrong");
    att_quarter_a: assert property (@(posedge clk_sys) disable iff (sys_rst)
        lib_running_s ##0 (library_attenuation == 2'h3)
        |=> drive_level == ($past(library_sample) >>> 2))
        else $error("quarter strength wrong");
    rt_gain_a: assert property (@(posedge clk_sys) disable iff (sys_rst)
        rt_running_s ##0 (library_attenuation != 2'h0)
        |=> drive_level == $past(realtime_drive_value))
        else $error("attenuation applied in real-time mode");
    rt_drive_a: assert property (@(posedge clk_sys) disable iff (sys_rst)
        rt_running_s |=> drive_level == $past(realtime_drive_value))
        else $error("real-time drive wrong");
    rt_read_a: assert property (@(posedge clk_sys) disable iff (sys_rst)
        reg_addr == hpc_pkg::OFS_RT_DRIVE |=> reg_rdata == $past(realtime_drive_value))
        else $error("real-time value read wrong");
    rt_store_a: assert property (@(posedge clk_sys) disable iff (sys_rst)
        rt_write_s |=> realtime_drive_value == $past(reg_wdata))
        else $error("real-time value not stored");
    rt_noatt_a: assert property (@(posedge clk_sys) disable iff (sys_rst)
        rt_write_s ##1 rt_running_s |=> drive_level == $past(reg_wdata, 2))
        else $error("new value not applied");
    go_cancel_a: assert property (@(posedge clk_sys) disable iff (sys_rst)
        !go_active |=> drive_level == 8'sh00 && !playback_step)
        else $error("no cancel");

    // ----------------------------------------
    // checks: first slot
    // ----------------------------------------
    slot_flag_a: assert property (@(posedge clk_sys) disable iff (sys_rst)
        slot_write_s |=> ##1 slot1_delay_flag == $past(reg_wdata[hpc_pkg::BIT_SLOT_DELAY], 2))
        else $error("slot delay flag wrong");
    slot_id_a: assert property (@(posedge clk_sys) disable iff (sys_rst)
        slot_write_s |=> ##1 slot1_waveform_id == $past(reg_wdata[6:0], 2))
        else $error("slot identifier wrong");
endmodule // hpc_regs
`default_nettype wire

/* File: hpc_host_model.sv */
// host model writing and reading the register port
`timescale 1ns/1ps
`default_nettype none
module hpc_host_model (
    // clock
    input wire logic clk_sys,
    // register port
    output logic reg_wr,
    output logic [7:0] reg_addr,
    output logic [7:0] reg_wdata,
    input wire logic [7:0] reg_rdata
);
    initial begin
        reg_wr = 1'b0;
        reg_addr = 8'h00;
        reg_wdata = 8'h00;
    end
    // reserved and read-only bits of the library word go out as zero
    task automatic wr(input logic [7:0] a, input logic [7:0] d);
        @(posedge clk_sys);
        reg_wr <= 1'b1;
        reg_addr <= a;
        reg_wdata <= (a == hpc_pkg::OFS_LIB_CFG) ? (d & 8'h63) : d;
        @(posedge clk_sys);
        reg_wr <= 1'b0;
        reg_wdata <= ~d;
    endtask
    task automatic rd(input logic [7:0] a, output logic [7:0] d);
        @(posedge clk_sys);
        reg_addr <= a;
        @(posedge clk_sys);
        #1;
        d = reg_rdata;
    endtask
endmodule // hpc_host_model
`default_nettype wire

/* File: test_haptic_playback_config_regs.sv */
// self-checking bench for the playback configuration registers
`timescale 1ns/1ps
`default_nettype none
module test_haptic_playback_config_regs;
    logic clk_sys = 1'b0;
    logic sys_rst = 1'b1;
    logic mode_realtime = 1'b0;
    logic go_active = 1'b0;
    logic signed [7:0] library_sample = 8'sh00;
    logic reg_wr, library_select, playback_step, slot1_delay_flag;
    logic [7:0] reg_addr, reg_wdata, reg_rdata, v, w;
    logic signed [7:0] drive_level;
    logic [6:0] slot1_waveform_id;
    logic [7:0] ra [4] = '{8'h0D, 8'h0E, 8'h0F, 8'h20};
    logic [7:0] rv [4] = '{hpc_pkg::RST_LIB_CFG, hpc_pkg::RST_RT_DRIVE,
        hpc_pkg::RST_SLOT_ONE, 8'h00};
    int err_total = 0;
    int comparisons = 0;
    int n;
    always #50 clk_sys = ~clk_sys;
    // small step counts keep the run short
    hpc_regs #(.STEP_SLOW(20), .STEP_FAST(4)) hpc_regs_i (.clk_sys(clk_sys), .sys_rst(sys_rst),
        .reg_wr(reg_wr), .reg_addr(reg_addr), .reg_wdata(reg_wdata), .reg_rdata(reg_rdata),
        .mode_realtime(mode_realtime), .go_active(go_active), .library_sample(library_sample),
        .library_select(library_select), .playback_step(playback_step),
        .drive_level(drive_level), .slot1_waveform_id(slot1_waveform_id),
        .slot1_delay_flag(slot1_delay_flag));
    hpc_host_model hpc_host_model_i (.clk_sys(clk_sys), .reg_wr(reg_wr), .reg_addr(reg_addr),
        .reg_wdata(reg_wdata), .reg_rdata(reg_rdata));
    task automatic chk(input logic [7:0] seen, input logic [7:0] exp);
        comparisons++;
        if (seen !== exp) begin
            err_total++;
            $display("[ERR] t=%0t seen=%h exp=%h", $time, seen, exp);
        end
    endtask
    function automatic logic [7:0] att(input logic signed [7:0] x, input logic [1:0] g);
        case (g)
            2'd0: return x;
            2'd1: return (x >>> 1) + (x >>> 2);
            2'd2: return x >>> 1;
            default: return x >>> 2;
        endcase
    endfunction
    task automatic settle();
        repeat (3) @(posedge clk_sys);
        #1;
    endtask
    task automatic wrap_up();
        $display("comparisons %0d mismatches %0d", comparisons, err_total);
        if (err_total == 0 && comparisons > 0) begin
            $display("ALL CHECKS OK");
        end else begin
            $display("CHECKS NOT OK");
        end
        $finish;
    endtask
    initial begin
        #2_000_000;
        err_total++;
        wrap_up();
    end
    initial begin
        void'($urandom(62));
        repeat (5) @(posedge clk_sys);
        sys_rst <= 1'b0;
        foreach (ra[i]) begin
            hpc_host_model_i.rd(ra[i], v);
            chk(v, rv[i]);
        end
        $display("test reset done");
        for (int i = 0; i < 2; i++) begin
            v = 8'($urandom() & 8'h23) | 8'(i << 6);
            hpc_host_model_i.wr(8'h0D, v);
            settle();
            chk({7'h00, library_select}, 8'(i));
            hpc_host_model_i.rd(8'h0D, v);
            chk({6'h00, v[7:6]}, 8'(2 + i));
        end
        $display("test library done");
        @(posedge clk_sys);
        go_active <= 1'b1;
        for (int g = 0; g < 4; g++) begin
            @(posedge clk_sys);
            library_sample <= (g == 3) ? 8'sh80 : 8'($urandom());
            hpc_host_model_i.wr(8'h0D, 8'(g));
            settle();
            chk(drive_level, att(library_sample, 2'(g)));
        end
        $display("test attenuation done");
        for (int i = 0; i < 2; i++) begin
            hpc_host_model_i.wr(8'h0D, 8'(i << 5));
            settle();
            n = 0;
            while (playback_step !== 1'b1 && n < 100) begin
                @(posedge clk_sys);
                #1;
                n++;
            end
            n = 0;
            do begin
                @(posedge clk_sys);
                #1;
                n++;
            end while (playback_step !== 1'b1 && n < 100);
            chk(8'(n), i ? 8'h04 : 8'h14);
        end
        $display("test interval done");
        hpc_host_model_i.wr(8'h0D, 8'h03);
        @(posedge clk_sys);
        mode_realtime <= 1'b1;
        for (int i = 0; i < 3; i++) begin
            v = (i == 0) ? 8'h80 : 8'($urandom());
            hpc_host_model_i.wr(8'h0E, v);
            settle();
            chk(drive_level, v);
        end
        @(posedge clk_sys);
        go_active <= 1'b0;
        settle();
        chk(drive_level, 8'h00);
        $display("test realtime done");
        w = 8'($urandom()) | 8'h80;
        hpc_host_model_i.wr(8'h0F, w);
        settle();
        chk({slot1_delay_flag, slot1_waveform_id}, w);
        hpc_host_model_i.rd(8'h0F, v);
        chk(v, w);
        $display("test slot done");
        @(posedge clk_sys);
        sys_rst <= 1'b1;
        repeat (2) @(posedge clk_sys);
        sys_rst <= 1'b0;
        foreach (ra[i]) begin
            hpc_host_model_i.rd(ra[i], v);
            chk(v, rv[i]);
        end
        chk({slot1_delay_flag, slot1_waveform_id}, hpc_pkg::RST_SLOT_ONE);
        $display("test second reset done");
        wrap_up();
    end
endmodule // test_haptic_playback_config_regs
`default_nettype wire
